// ---- pkg/adc_seq_pkg.sv ----
package adc_seq_pkg;
  localparam int ADDR_W    = 8;
  localparam int DATA_W    = 16;
  localparam int RES_W     = 12;
  localparam int CH_W      = 4;
  localparam int NUM_CH    = 16;
  localparam int TEMP_W    = 10;
  localparam int NUM_SLOTS = 18;
  localparam int SLOT_W    = 5;

  localparam logic [ADDR_W-1:0] STATUS_ADDR      = 8'h4f;
  localparam logic [ADDR_W-1:0] SEL_LOW_ADDR     = 8'h50;
  localparam logic [ADDR_W-1:0] SEL_HIGH_ADDR    = 8'h51;
  localparam logic [ADDR_W-1:0] RESULT_BASE_ADDR = 8'h60;
  localparam logic [ADDR_W-1:0] RESULT_COUNT     = 8'h10;

  localparam logic [DATA_W-1:0] SEL_RESET    = 16'h0000;
  localparam logic [DATA_W-1:0] SEL_LOW_MASK = 16'h7fff;
  localparam logic [DATA_W-1:0] SEL_HI_MASK  = 16'h7000;
  localparam logic [DATA_W-1:0] STATUS_RESET = 16'h0000;

  localparam int R1_OVER_BIT  = 7;
  localparam int R2_UNDER_BIT = 6;
  localparam int R2_OVER_BIT  = 5;
  localparam int R1_FAULT_BIT = 4;
  localparam int R2_FAULT_BIT = 3;
  localparam int DIE_HOT_BIT  = 2;

  localparam int SE0_BIT  = 14;
  localparam int SE1_BIT  = 13;
  localparam int SE2_BIT  = 11;
  localparam int SE3_BIT  = 10;
  localparam int SE13_BIT = 14;

  localparam int SLOT_DFA        = 2;
  localparam int SLOT_DFB        = 5;
  localparam int SLOT_HIGH_FIRST = 15;
  localparam int SLOT_SE4        = 6;
  localparam int SLOT_SE4_SHIFT  = 2;
  localparam int PAIR_A_POS_CH   = 0;
  localparam int PAIR_B_POS_CH   = 2;

  localparam int THERM_SET_C  = 150;
  localparam int THERM_HYST_C = 8;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_ISSUE, SEQ_WAIT} seq_state_t;
endpackage : adc_seq_pkg

// ---- rtl/adc_seq_alarm.sv ----
// Functional notes
// - Remote one over flag, bit 7, when enabled
// - Remote two under flag, bit 6, when enabled
// - Remote two over flag, bit 5, when enabled
// - Remote one fault flag, bit 4, when enabled
// - Remote two fault flag, bit 3, when enabled
// - Die overheat flag at 150 C or above
// - Overheat flag zero while on-chip sensor off
// - Overheat clears only 8 C below set point
// - Visit low register 14..0, then high 14..12
// - Convert only inputs whose select bit is set
// - Single-ended results stored straight binary per channel
// - Pair A differential result into result zero
// - Pair B differential result into result two
// - Bits 14 or 13 set suppress pair A
// - Bits 11 or 10 set suppress pair B
// - Differential only when both single bits clear
// - Low bits 8..0 enable inputs 4..12
// - High bits 14..12 enable inputs 13..15
// - Latched flags hold until cleared and read, except overheat, which drops once the sensor is off
`timescale 1ns/1ps
module adc_seq_alarm (
  input  wire logic                                   clock,
  input  wire logic                                   reset_n,
  input  wire logic                                   clock_enable,
  input  wire logic [adc_seq_pkg::ADDR_W-1:0]         reg_address,
  input  wire logic [adc_seq_pkg::DATA_W-1:0]         reg_write_data,
  input  wire logic                                   reg_write_strobe,
  input  wire logic                                   reg_read_strobe,
  output logic      [adc_seq_pkg::DATA_W-1:0]         reg_read_data,
  input  wire logic                                   remote_one_enable,
  input  wire logic                                   remote_two_enable,
  input  wire logic                                   on_chip_temp_sensor,
  input  wire logic                                   flag_hold_disable,
  input  wire logic                                   remote_one_over_cond,
  input  wire logic                                   remote_two_under_cond,
  input  wire logic                                   remote_two_over_cond,
  input  wire logic                                   remote_one_fault_cond,
  input  wire logic                                   remote_two_fault_cond,
  input  wire logic signed [adc_seq_pkg::TEMP_W-1:0]  die_temp,
  input  wire logic                                   start_sweep,
  input  wire logic                                   conv_done,
  input  wire logic [adc_seq_pkg::RES_W-1:0]          conv_code,
  output logic                                        conv_start,
  output logic      [adc_seq_pkg::CH_W-1:0]           conv_channel,
  output logic                                        conv_differential,
  output logic                                        sweep_busy
);
  import adc_seq_pkg::*;

  localparam logic signed [TEMP_W-1:0] SET_T   = TEMP_W'(THERM_SET_C);
  localparam logic signed [TEMP_W-1:0] CLEAR_T = TEMP_W'(THERM_SET_C - THERM_HYST_C);

  function automatic logic slot_bit(input int s, input logic [DATA_W-1:0] lo,
                                    input logic [DATA_W-1:0] hi);
    if (s < SLOT_HIGH_FIRST)
      return lo[SE0_BIT - s];
    return hi[SE13_BIT - (s - SLOT_HIGH_FIRST)];
  endfunction : slot_bit

  function automatic logic slot_active(input int s, input logic [DATA_W-1:0] lo,
                                       input logic [DATA_W-1:0] hi);
    logic b;
    b = slot_bit(s, lo, hi);
    if (s == SLOT_DFA)
      b = b & ~lo[SE0_BIT] & ~lo[SE1_BIT];
    if (s == SLOT_DFB)
      b = b & ~lo[SE2_BIT] & ~lo[SE3_BIT];
    return b;
  endfunction : slot_active

  function automatic logic [CH_W-1:0] slot_channel(input int s);
    logic [CH_W-1:0] c;
    if (s < SLOT_DFA)
      c = CH_W'(s);
    else if (s == SLOT_DFA)
      c = CH_W'(PAIR_A_POS_CH);
    else if (s < SLOT_DFB)
      c = CH_W'(s - 1);
    else if (s == SLOT_DFB)
      c = CH_W'(PAIR_B_POS_CH);
    else
      c = CH_W'(s - SLOT_SE4_SHIFT);
    return c;
  endfunction : slot_channel

  // Lowest active slot at or after from; top bit says one was found
  function automatic logic [SLOT_W:0] find_next(input int from, input logic [DATA_W-1:0] lo,
                                                input logic [DATA_W-1:0] hi);
    logic [SLOT_W:0] r;
    r = '0;
    for (int s = NUM_SLOTS - 1; s >= 0; s--)
    begin
      if (s >= from && slot_active(s, lo, hi))
        r = {1'b1, SLOT_W'(s)};
    end
    return r;
  endfunction : find_next

  logic [DATA_W-1:0] sel_low;
  logic [DATA_W-1:0] sel_high;
  logic [DATA_W-1:0] next_sel_low;
  logic [DATA_W-1:0] next_sel_high;
  logic [DATA_W-1:0] next_read_data;
  logic [DATA_W-1:0] status_flags;
  logic [DATA_W-1:0] next_status_flags;
  logic [DATA_W-1:0] flag_cond;
  logic              therm_active;
  logic              next_therm_active;
  logic              status_read;
  logic [ADDR_W-1:0] result_offset;
  logic [RES_W-1:0]  results [NUM_CH];
  logic [RES_W-1:0]  next_results [NUM_CH];
  seq_state_t        state;
  seq_state_t        next_state;
  logic [SLOT_W-1:0] cur_slot;
  logic [SLOT_W-1:0] next_cur_slot;
  logic [DATA_W-1:0] sweep_low;
  logic [DATA_W-1:0] sweep_high;
  logic [DATA_W-1:0] next_sweep_low;
  logic [DATA_W-1:0] next_sweep_high;
  logic              next_conv_start;
  logic [CH_W-1:0]   next_conv_channel;
  logic              next_conv_differential;
  logic              next_sweep_busy;
  logic [SLOT_W:0]   pick;

  assign status_read   = reg_read_strobe && reg_address == STATUS_ADDR;
  assign result_offset = reg_address - RESULT_BASE_ADDR;

  // Register bus
  always_comb
  begin
    next_sel_low   = sel_low;
    next_sel_high  = sel_high;
    next_read_data = '0;
    if (reg_write_strobe && reg_address == SEL_LOW_ADDR)
      next_sel_low = reg_write_data & SEL_LOW_MASK;
    if (reg_write_strobe && reg_address == SEL_HIGH_ADDR)
      next_sel_high = reg_write_data & SEL_HI_MASK;
    if (reg_read_strobe)
    begin
      if (reg_address == STATUS_ADDR)
        next_read_data = status_flags;
      else if (reg_address == SEL_LOW_ADDR)
        next_read_data = sel_low;
      else if (reg_address == SEL_HIGH_ADDR)
        next_read_data = sel_high;
      else if (result_offset < RESULT_COUNT)
        next_read_data = DATA_W'(results[result_offset[CH_W-1:0]]);
    end
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sel_low       <= SEL_RESET;
      sel_high      <= SEL_RESET;
      reg_read_data <= '0;
    end
    else if (clock_enable)
    begin
      sel_low       <= next_sel_low;
      sel_high      <= next_sel_high;
      reg_read_data <= next_read_data;
    end
  end

  // Alarm flags
  always_comb
  begin
    flag_cond               = '0;
    flag_cond[R1_OVER_BIT]  = remote_one_over_cond & remote_one_enable;
    flag_cond[R2_UNDER_BIT] = remote_two_under_cond & remote_two_enable;
    flag_cond[R2_OVER_BIT]  = remote_two_over_cond & remote_two_enable;
    flag_cond[R1_FAULT_BIT] = remote_one_fault_cond & remote_one_enable;
    flag_cond[R2_FAULT_BIT] = remote_two_fault_cond & remote_two_enable;
    flag_cond[DIE_HOT_BIT]  = therm_active;
    next_therm_active = therm_active;
    if (!on_chip_temp_sensor)
      next_therm_active = 1'b0;
    else if (die_temp >= SET_T)
      next_therm_active = 1'b1;
    else if (die_temp <= CLEAR_T)
      next_therm_active = 1'b0;
    // A read never hides a live condition: the set term wins
    if (flag_hold_disable)
      next_status_flags = flag_cond;
    else if (status_read)
      next_status_flags = flag_cond;
    else
      next_status_flags = status_flags | flag_cond;
    if (!on_chip_temp_sensor)
      next_status_flags[DIE_HOT_BIT] = 1'b0;
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      status_flags <= STATUS_RESET;
      therm_active <= 1'b0;
    end
    else if (clock_enable)
    begin
      status_flags <= next_status_flags;
      therm_active <= next_therm_active;
    end
  end

  // Channel sequencer; selections are snapshotted so a mid-sweep write cannot reorder it
  always_comb
  begin
    next_state      = state;
    next_cur_slot   = cur_slot;
    next_sweep_low  = sweep_low;
    next_sweep_high = sweep_high;
    next_conv_start = 1'b0;
    next_results    = results;
    pick            = '0;
    unique case (state)
      SEQ_IDLE:
      begin
        if (start_sweep)
        begin
          next_sweep_low  = sel_low;
          next_sweep_high = sel_high;
          pick = find_next(0, sel_low, sel_high);
          if (pick[SLOT_W])
          begin
            next_cur_slot = pick[SLOT_W-1:0];
            next_state    = SEQ_ISSUE;
          end
        end
      end
      SEQ_ISSUE:
      begin
        next_conv_start = 1'b1;
        next_state      = SEQ_WAIT;
      end
      SEQ_WAIT:
      begin
        if (conv_done)
        begin
          // Converter supplies binary or two's complement per the mode it was given
          next_results[conv_channel] = conv_code;
          pick = find_next(int'(cur_slot) + 1, sweep_low, sweep_high);
          if (pick[SLOT_W])
          begin
            next_cur_slot = pick[SLOT_W-1:0];
            next_state    = SEQ_ISSUE;
          end
          else
            next_state = SEQ_IDLE;
        end
      end
    endcase
    next_conv_channel      = slot_channel(int'(next_cur_slot));
    next_conv_differential = next_cur_slot == SLOT_W'(SLOT_DFA)
                             || next_cur_slot == SLOT_W'(SLOT_DFB);
    next_sweep_busy        = next_state != SEQ_IDLE;
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state             <= SEQ_IDLE;
      cur_slot          <= '0;
      sweep_low         <= SEL_RESET;
      sweep_high        <= SEL_RESET;
      conv_start        <= 1'b0;
      conv_channel      <= '0;
      conv_differential <= 1'b0;
      sweep_busy        <= 1'b0;
      for (int i = 0; i < NUM_CH; i++)
        results[i] <= '0;
    end
    else if (clock_enable)
    begin
      state             <= next_state;
      cur_slot          <= next_cur_slot;
      sweep_low         <= next_sweep_low;
      sweep_high        <= next_sweep_high;
      conv_start        <= next_conv_start;
      conv_channel      <= next_conv_channel;
      conv_differential <= next_conv_differential;
      sweep_busy        <= next_sweep_busy;
      results           <= next_results;
    end
  end

  default clocking dcb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  property p_r1_over;
    clock_enable && flag_hold_disable
    |=> status_flags[R1_OVER_BIT] == $past(remote_one_over_cond && remote_one_enable);
  endproperty
  a_r1_over: assert property (p_r1_over) else $error("remote one over flag wrong");

  property p_r2_under;
    clock_enable && flag_hold_disable
    |=> status_flags[R2_UNDER_BIT] == $past(remote_two_under_cond && remote_two_enable);
  endproperty
  a_r2_under: assert property (p_r2_under) else $error("remote two under flag wrong");

  property p_r2_over;
    clock_enable && flag_hold_disable
    |=> status_flags[R2_OVER_BIT] == $past(remote_two_over_cond && remote_two_enable);
  endproperty
  a_r2_over: assert property (p_r2_over) else $error("remote two over flag wrong");

  property p_r1_fault;
    clock_enable && !remote_one_enable && flag_hold_disable |=> !status_flags[R1_FAULT_BIT];
  endproperty
  a_r1_fault: assert property (p_r1_fault) else $error("remote one fault not gated");

  property p_r2_fault;
    clock_enable && remote_two_enable && remote_two_fault_cond |=> status_flags[R2_FAULT_BIT];
  endproperty
  a_r2_fault: assert property (p_r2_fault) else $error("remote two fault missed");

  sequence s_hot;
    clock_enable && on_chip_temp_sensor && die_temp >= SET_T;
  endsequence
  property p_hot;
    s_hot ##1 (clock_enable && on_chip_temp_sensor) |=> status_flags[DIE_HOT_BIT];
  endproperty
  a_hot: assert property (p_hot) else $error("overheat flag not set");

  property p_sensor_off;
    clock_enable && !on_chip_temp_sensor |=> !status_flags[DIE_HOT_BIT] && !therm_active;
  endproperty
  a_sensor_off: assert property (p_sensor_off) else $error("overheat flag while off");

  property p_hyst;
    therm_active && clock_enable && on_chip_temp_sensor && die_temp > CLEAR_T |=> therm_active;
  endproperty
  a_hyst: assert property (p_hyst) else $error("overheat released early");

  property p_only_selected;
    conv_start |-> slot_active(int'(cur_slot), sweep_low, sweep_high);
  endproperty
  a_only_selected: assert property (p_only_selected) else $error("unselected input");

  property p_pair_a;
    conv_start && conv_differential && conv_channel == CH_W'(PAIR_A_POS_CH)
    |-> !sweep_low[SE0_BIT] && !sweep_low[SE1_BIT];
  endproperty
  a_pair_a: assert property (p_pair_a) else $error("pair A used with single bits");

  property p_pair_b;
    conv_start && conv_differential && conv_channel == CH_W'(PAIR_B_POS_CH)
    |-> !sweep_low[SE2_BIT] && !sweep_low[SE3_BIT];
  endproperty
  a_pair_b: assert property (p_pair_b) else $error("pair B used with single bits");

  property p_hold;
    clock_enable && !flag_hold_disable && !status_read && status_flags[R1_OVER_BIT]
    |=> status_flags[R1_OVER_BIT];
  endproperty
  a_hold: assert property (p_hold) else $error("latched flag dropped");

  property p_reserved;
    clock_enable && reg_read_strobe && reg_address == SEL_HIGH_ADDR
    |=> (reg_read_data & ~SEL_HI_MASK) == '0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits not zero");
endmodule : adc_seq_alarm

// ---- dv/conv_model.sv ----
`timescale 1ns/1ps
module conv_model (
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        conv_start,
  input  wire logic [3:0]  conv_channel,
  input  wire logic        conv_differential,
  input  wire integer      delay,
  output logic             conv_done,
  output logic      [11:0] conv_code
);
  int          cnt;
  logic        busy;
  logic [11:0] code_q;
  // Code outside a done pulse toggles every cycle so a stale sample shows
  always @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      busy      <= 1'b0;
      conv_done <= 1'b0;
      conv_code <= 12'h0a5;
      cnt       <= 0;
    end
    else
    begin
      conv_done <= 1'b0;
      conv_code <= ~conv_code;
      if (conv_start)
      begin
        busy   <= 1'b1;
        cnt    <= delay;
        code_q <= 12'h300 + {conv_channel, conv_differential};
      end
      else if (busy && cnt == 0)
      begin
        busy      <= 1'b0;
        conv_done <= 1'b1;
        conv_code <= code_q;
      end
      else if (busy)
        cnt <= cnt - 1;
    end
  end
endmodule : conv_model

// ---- dv/adc_seq_alarm_tb.sv ----
`timescale 1ns/1ps
module adc_seq_alarm_tb;
  import adc_seq_pkg::*;
  logic        clock, reset_n, wstb, rstb, start_sweep, hold_dis, ce;
  logic [7:0]  addr;
  logic [15:0] wdata, rdata;
  logic        en1, en2, lt_en, c1o, c2u, c2o, c1f, c2f;
  logic signed [9:0] die_temp;
  logic        conv_done, conv_start, conv_diff, sweep_busy;
  logic [11:0] conv_code;
  logic [3:0]  conv_channel;
  int          delay, bad_count, tests_run, cycles;
  logic [4:0]  seen[$];

  adc_seq_alarm uut (.clock(clock), .reset_n(reset_n), .clock_enable(ce),
    .reg_address(addr), .reg_write_data(wdata), .reg_write_strobe(wstb),
    .reg_read_strobe(rstb), .reg_read_data(rdata), .remote_one_enable(en1),
    .remote_two_enable(en2), .on_chip_temp_sensor(lt_en), .flag_hold_disable(hold_dis),
    .remote_one_over_cond(c1o), .remote_two_under_cond(c2u),
    .remote_two_over_cond(c2o), .remote_one_fault_cond(c1f),
    .remote_two_fault_cond(c2f), .die_temp(die_temp), .start_sweep(start_sweep),
    .conv_done(conv_done), .conv_code(conv_code), .conv_start(conv_start),
    .conv_channel(conv_channel), .conv_differential(conv_diff),
    .sweep_busy(sweep_busy));

  conv_model far_end (.clock(clock), .reset_n(reset_n), .conv_start(conv_start),
    .conv_channel(conv_channel), .conv_differential(conv_diff), .delay(delay),
    .conv_done(conv_done), .conv_code(conv_code));

  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  always @(posedge clock)
    if (conv_start === 1'b1)
      seen.push_back({conv_channel, conv_diff});

  // Generous ceiling; the whole run needs well under a thousand cycles
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      test_done();
    end
  end

  task automatic test_done();
    if (bad_count == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : test_done

  task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e)
    begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      bad_count++;
    end
  endtask : cmp

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wstb  <= 1'b1;
    @(posedge clock);
    wstb  <= 1'b0;
  endtask : wr

  task automatic rdc(input string nm, input logic [7:0] a, input logic [15:0] e);
    @(posedge clock);
    addr <= a;
    rstb <= 1'b1;
    @(posedge clock);
    rstb <= 1'b0;
    #1 cmp(nm, e, rdata);
  endtask : rdc

  task automatic run_sweep(input logic [15:0] lo, input logic [15:0] hi, input int d);
    int n;
    delay = d;
    seen.delete();
    wr(SEL_LOW_ADDR, lo);
    wr(SEL_HIGH_ADDR, hi);
    @(posedge clock);
    start_sweep <= 1'b1;
    @(posedge clock);
    start_sweep <= 1'b0;
    repeat (2) @(posedge clock);
    n = 0;
    while (sweep_busy !== 1'b0 && n < 500)
    begin
      @(posedge clock);
      n++;
    end
  endtask : run_sweep

  task automatic order(input logic [4:0] e[6]);
    cmp("slot count", 16'h0006, 16'(seen.size()));
    foreach (e[i])
      cmp("slot", {11'h000, e[i]}, (i < seen.size()) ? {11'h000, seen[i]} : 16'hffff);
  endtask : order

  task automatic wait_set(input int n);
    repeat (n) @(posedge clock);
  endtask : wait_set

  initial
  begin
    {wstb, rstb, start_sweep, en1, en2, lt_en, hold_dis} = '0;
    ce = 1'b1;
    {c1o, c2u, c2o, c1f, c2f} = '0;
    {addr, wdata, cycles, bad_count, tests_run, delay} = '0;
    die_temp = 10'sd25;
    reset_n  = 1'b0;
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    rdc("sel low rst", SEL_LOW_ADDR, 16'h0000);
    rdc("sel high rst", SEL_HIGH_ADDR, 16'h0000);
    wr(SEL_LOW_ADDR, 16'hffff);
    rdc("sel low rsv", SEL_LOW_ADDR, 16'h7fff);
    wr(SEL_HIGH_ADDR, 16'hffff);
    rdc("sel high rsv", SEL_HIGH_ADDR, 16'h7000);
    rdc("unmapped", 8'h30, 16'h0000);
    run_sweep(16'h7201, 16'h5000, 3);
    order('{5'd0, 5'd2, 5'd5, 5'd24, 5'd26, 5'd30});
    rdc("ch0 result", RESULT_BASE_ADDR + 8'h00, 16'h0300);
    rdc("ch1 result", RESULT_BASE_ADDR + 8'h01, 16'h0302);
    rdc("ch12 result", RESULT_BASE_ADDR + 8'h0c, 16'h0318);
    rdc("ch13 result", RESULT_BASE_ADDR + 8'h0d, 16'h031a);
    rdc("ch15 result", RESULT_BASE_ADDR + 8'h0f, 16'h031e);
    rdc("diff b result", RESULT_BASE_ADDR + 8'h02, 16'h0305);
    rdc("unselected", RESULT_BASE_ADDR + 8'h03, 16'h0000);
    run_sweep(16'h1f80, 16'h2000, 0);
    order('{5'd1, 5'd4, 5'd6, 5'd8, 5'd10, 5'd28});
    rdc("diff a result", RESULT_BASE_ADDR, 16'h0301);
    rdc("ch14 result", RESULT_BASE_ADDR + 8'h0e, 16'h031c);
    // A write while the enable is low must leave the selection untouched
    ce <= 1'b0;
    wr(SEL_LOW_ADDR, 16'h0001);
    ce <= 1'b1;
    rdc("sel low frozen", SEL_LOW_ADDR, 16'h1f80);
    hold_dis <= 1'b1;
    {en1, en2, c1o, c2u, c2o, c1f, c2f} <= 7'h7f;
    wait_set(3);
    rdc("flags on", STATUS_ADDR, 16'h00f8);
    {en1, en2} <= 2'b00;
    wait_set(3);
    rdc("flags off", STATUS_ADDR, 16'h0000);
    {c2u, c2o, c1f, c2f} <= 4'h0;
    hold_dis <= 1'b0;
    en1      <= 1'b1;
    wait_set(3);
    c1o <= 1'b0;
    wait_set(3);
    rdc("latched", STATUS_ADDR, 16'h0080);
    rdc("cleared", STATUS_ADDR, 16'h0000);
    hold_dis <= 1'b1;
    lt_en    <= 1'b1;
    die_temp <= 10'sd150;
    wait_set(4);
    rdc("die set", STATUS_ADDR, 16'h0004);
    die_temp <= 10'sd143;
    wait_set(4);
    rdc("die hyst", STATUS_ADDR, 16'h0004);
    die_temp <= 10'sd142;
    wait_set(4);
    rdc("die clear", STATUS_ADDR, 16'h0000);
    die_temp <= 10'sd200;
    lt_en    <= 1'b0;
    wait_set(4);
    rdc("die off", STATUS_ADDR, 16'h0000);
    test_done();
  end
endmodule : adc_seq_alarm_tb
